// ---- hdl/cable_diag_pkg.sv ----
package cable_diag_pkg;
  // Register addresses in the management space
  localparam logic [4:0] addr_reflect_window = 5'h17;
  localparam logic [4:0] addr_reflect_peak_result = 5'h18;
  localparam logic [4:0] addr_reflect_threshold_result = 5'h19;
  localparam logic [4:0] addr_variance_control = 5'h1a;
  localparam logic [4:0] addr_variance_sum_data = 5'h1b;
  // Window fields
  localparam int window_start_lsb = 8;
  localparam int window_stop_lsb = 0;
  localparam logic [7:0] window_start_reset = 8'h00;
  localparam logic [7:0] window_stop_reset = 8'hff;
  // Result fields
  localparam int peak_value_lsb = 8;
  localparam int threshold_met_bit = 8;
  // Variance control fields
  localparam int var_ready_bit = 15;
  localparam int var_freeze_bit = 3;
  localparam int var_timer_lsb = 1;
  localparam int var_enable_bit = 0;
  localparam logic [1:0] var_timer_reset = 2'h0;
  // Reflect control bits held outside this block
  localparam int send_pulse_bit_pos = 11;
  localparam int negative_peak_mode_pos = 7;
  // One nominal millisecond is 2**17 sample clocks
  localparam int ms_unit_log2 = 17;
endpackage

// ---- hdl/variance_timer.sv ----
`timescale 1ns/1ps
module variance_timer #(
  parameter int unit_log2 = cable_diag_pkg::ms_unit_log2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [1:0] period_sel,
  // Period elapsed
  output logic elapsed
);
  localparam int cw = unit_log2 + 4;
  logic [cw-1:0] count;
  logic [cw-1:0] next_count;
  logic [cw-1:0] limit;
  logic next_elapsed;

  if (unit_log2 < 1 || unit_log2 > 24) begin : bad_unit_check
    $error("variance_timer: bad unit_log2");
  end

  always_comb begin
    limit = cw'(({2'b00, period_sel} + 4'h1) * 2) << unit_log2; // see RULE_12 see RULE_14
    next_count = count;
    next_elapsed = 1'b0;
    if (!run || restart) begin
      next_count = '0; // see RULE_13
    end else if (count == limit - cw'(1)) begin
      next_count = '0;
      next_elapsed = 1'b1; // see RULE_13
    end else begin
      next_count = count + cw'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      elapsed <= 1'b0;
    end else begin
      count <= next_count;
      elapsed <= next_elapsed;
    end
  end
endmodule

// ---- hdl/cable_diag_result_regs.sv ----
`timescale 1ns/1ps
// How it works
// RULE_01: Window and captured times count 8ns clocks from pulse launch.
// RULE_02: Window start 15:8 resets 0, stop 7:0 resets 0xFF; monitor between.
// RULE_03: Software sets stop not below start before launching.
// RULE_04: Results valid once send-pulse bit 11 returns to zero.
// RULE_05: Peak value 13:8 holds max, or min in negative-peak mode.
// RULE_06: Peak time 7:0 is first sample reaching the peak; ties ignored.
// RULE_07: Threshold-met bit 8 set if any window sample met threshold.
// RULE_08: Threshold time 7:0 is first sample meeting threshold.
// RULE_09: Reserved bits read zero and ignore writes.
// RULE_10: Ready bit 15 sets on new sum, clears after two data reads.
// RULE_11: Freeze bit 3 blocks loading, clears after two data reads.
// RULE_12: Timer field 2:1 selects 2, 4, 6 or 8 ms period.
// RULE_13: Writing the timer restarts computation; sum loads each period.
// RULE_14: One millisecond is 2**17 clocks of 8ns.
// RULE_15: Enable bit 0 runs computation; resets off.
// RULE_16: First data read returns low half, second read the high half.
// RULE_17: Software sets freeze on ready before reading the data.
// RULE_18: Data contents guaranteed only while ready is set.
// RULE_19: Send-pulse launches pulse, arms capture, self-clears when done.
// RULE_20: Negative-peak mode bit selects positive or negative peak.
// RULE_21: Threshold met above it in positive mode, below in negative.
// RULE_22: Sample counter runs from launch; capture stops past window stop.
module cable_diag_result_regs #(
  parameter int unit_log2 = cable_diag_pkg::ms_unit_log2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Management register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Reflect control bits from the control register
  input wire logic send_pulse_set,
  input wire logic negative_peak_mode,
  input wire logic [5:0] rx_threshold,
  output logic send_pulse_bit,
  // Pulse launch and receive samples
  output logic pulse_launch,
  input wire logic [5:0] sample,
  // Variance engine
  input wire logic variance_sample_valid,
  input wire logic [31:0] variance_term
);
  typedef enum logic [0:0] {cap_idle, cap_run} cap_state_e;
  cap_state_e cap_state, next_cap_state;
  logic [7:0] window_start_time, next_window_start_time;
  logic [7:0] window_stop_time, next_window_stop_time;
  logic [7:0] sample_time, next_sample_time;
  logic [5:0] peak_value, next_peak_value;
  logic [7:0] peak_time, next_peak_time;
  logic peak_seen, next_peak_seen;
  logic threshold_met_flag, next_threshold_met_flag;
  logic [7:0] threshold_time, next_threshold_time;
  logic next_pulse_launch;
  logic in_window, meets_thr, better;

  logic var_ready, next_var_ready;
  logic var_freeze, next_var_freeze;
  logic [1:0] var_timer, next_var_timer;
  logic var_enable, next_var_enable;
  logic [31:0] var_acc, next_var_acc;
  logic [31:0] var_sum, next_var_sum;
  logic half_sel, next_half_sel;
  logic [15:0] next_reg_rdata;
  logic period_done, timer_written, data_read;

  if (unit_log2 < 1 || unit_log2 > 24) begin : bad_unit_check
    $error("cable_diag_result_regs: bad unit_log2");
  end

  // Pulse capture
  always_comb begin
    next_cap_state = cap_state;
    next_window_start_time = window_start_time;
    next_window_stop_time = window_stop_time;
    next_sample_time = sample_time;
    next_peak_value = peak_value;
    next_peak_time = peak_time;
    next_peak_seen = peak_seen;
    next_threshold_met_flag = threshold_met_flag;
    next_threshold_time = threshold_time;
    next_pulse_launch = 1'b0;
    in_window = (sample_time >= window_start_time) && (sample_time <= window_stop_time); // see RULE_02
    meets_thr = negative_peak_mode ? (sample < rx_threshold) : (sample > rx_threshold); // see RULE_21
    better = negative_peak_mode ? (sample < peak_value) : (sample > peak_value); // see RULE_05 see RULE_20
    if (reg_wr && reg_addr == cable_diag_pkg::addr_reflect_window) begin
      next_window_start_time = reg_wdata[cable_diag_pkg::window_start_lsb +: 8]; // see RULE_02
      next_window_stop_time = reg_wdata[cable_diag_pkg::window_stop_lsb +: 8];
    end
    case (cap_state)
      cap_idle: begin
        if (send_pulse_set) begin
          next_cap_state = cap_run; // see RULE_19
          next_pulse_launch = 1'b1;
          next_sample_time = 8'h00; // see RULE_01
          next_peak_seen = 1'b0;
          next_peak_value = 6'h00;
          next_peak_time = 8'h00;
          next_threshold_met_flag = 1'b0;
          next_threshold_time = 8'h00;
        end
      end
      cap_run: begin
        if (in_window) begin
          if (!peak_seen || better) begin
            next_peak_value = sample; // see RULE_05
            next_peak_time = sample_time; // see RULE_06
            next_peak_seen = 1'b1;
          end
          if (meets_thr && !threshold_met_flag) begin
            next_threshold_met_flag = 1'b1; // see RULE_07
            next_threshold_time = sample_time; // see RULE_08
          end
        end
        if (sample_time >= window_stop_time) begin
          next_cap_state = cap_idle; // see RULE_22 see RULE_04
        end else begin
          next_sample_time = sample_time + 8'h01; // see RULE_01
        end
      end
      default: next_cap_state = cap_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cap_state <= cap_idle;
      window_start_time <= cable_diag_pkg::window_start_reset;
      window_stop_time <= cable_diag_pkg::window_stop_reset;
      sample_time <= 8'h00;
      peak_value <= 6'h00;
      peak_time <= 8'h00;
      peak_seen <= 1'b0;
      threshold_met_flag <= 1'b0;
      threshold_time <= 8'h00;
      pulse_launch <= 1'b0;
    end else begin
      cap_state <= next_cap_state;
      window_start_time <= next_window_start_time;
      window_stop_time <= next_window_stop_time;
      sample_time <= next_sample_time;
      peak_value <= next_peak_value;
      peak_time <= next_peak_time;
      peak_seen <= next_peak_seen;
      threshold_met_flag <= next_threshold_met_flag;
      threshold_time <= next_threshold_time;
      pulse_launch <= next_pulse_launch;
    end
  end

  assign send_pulse_bit = (cap_state == cap_run); // see RULE_19 see RULE_04

  // Variance period timer
  assign timer_written = reg_wr && reg_addr == cable_diag_pkg::addr_variance_control;
  assign data_read = reg_rd && reg_addr == cable_diag_pkg::addr_variance_sum_data;

  variance_timer #(
    .unit_log2(unit_log2)
  ) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .run(var_enable), // see RULE_15
    .restart(timer_written), // see RULE_13
    .period_sel(var_timer),
    .elapsed(period_done)
  );

  // Variance registers
  always_comb begin
    next_var_ready = var_ready;
    next_var_freeze = var_freeze;
    next_var_timer = var_timer;
    next_var_enable = var_enable;
    next_var_acc = var_acc;
    next_var_sum = var_sum;
    next_half_sel = half_sel;
    if (timer_written) begin
      next_var_freeze = reg_wdata[cable_diag_pkg::var_freeze_bit];
      next_var_timer = reg_wdata[cable_diag_pkg::var_timer_lsb +: 2]; // see RULE_12
      next_var_enable = reg_wdata[cable_diag_pkg::var_enable_bit]; // see RULE_15
      next_var_acc = 32'h0000_0000; // see RULE_13
      next_half_sel = 1'b0;
    end
    if (data_read) begin
      next_half_sel = ~half_sel; // see RULE_16
      if (half_sel) begin
        next_var_ready = 1'b0; // see RULE_10
        next_var_freeze = 1'b0; // see RULE_11
      end
    end
    if (!var_enable) begin
      next_var_acc = 32'h0000_0000; // see RULE_15
    end else if (!timer_written) begin
      if (period_done) begin
        next_var_acc = 32'h0000_0000;
        if (!var_freeze) begin
          next_var_sum = var_acc; // see RULE_11 see RULE_13
          next_var_ready = 1'b1; // see RULE_10
        end
      end else if (variance_sample_valid) begin
        next_var_acc = var_acc + variance_term;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      var_ready <= 1'b0;
      var_freeze <= 1'b0;
      var_timer <= cable_diag_pkg::var_timer_reset;
      var_enable <= 1'b0;
      var_acc <= 32'h0000_0000;
      var_sum <= 32'h0000_0000;
      half_sel <= 1'b0;
    end else begin
      var_ready <= next_var_ready;
      var_freeze <= next_var_freeze;
      var_timer <= next_var_timer;
      var_enable <= next_var_enable;
      var_acc <= next_var_acc;
      var_sum <= next_var_sum;
      half_sel <= next_half_sel;
    end
  end

  // Read data
  always_comb begin
    next_reg_rdata = 16'h0000; // see RULE_09
    case (reg_addr)
      cable_diag_pkg::addr_reflect_window: begin
        next_reg_rdata = {window_start_time, window_stop_time};
      end
      cable_diag_pkg::addr_reflect_peak_result: begin
        next_reg_rdata = {2'b00, peak_value, peak_time}; // see RULE_09
      end
      cable_diag_pkg::addr_reflect_threshold_result: begin
        next_reg_rdata = {7'h00, threshold_met_flag, threshold_time}; // see RULE_09
      end
      cable_diag_pkg::addr_variance_control: begin
        next_reg_rdata[cable_diag_pkg::var_ready_bit] = var_ready;
        next_reg_rdata[cable_diag_pkg::var_freeze_bit] = var_freeze;
        next_reg_rdata[cable_diag_pkg::var_timer_lsb +: 2] = var_timer;
        next_reg_rdata[cable_diag_pkg::var_enable_bit] = var_enable;
      end
      cable_diag_pkg::addr_variance_sum_data: begin
        next_reg_rdata = half_sel ? var_sum[31:16] : var_sum[15:0]; // see RULE_16 see RULE_18
      end
      default: next_reg_rdata = 16'h0000;
    endcase
    if (!reg_rd) begin
      next_reg_rdata = reg_rdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule

// ---- dv/cable_diag_result_regs_props.sv ----
`timescale 1ns/1ps
module cable_diag_result_regs_props #(
  parameter int unit_log2 = 17
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register access
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  // Capture
  input wire logic send_pulse_set,
  input wire logic send_pulse_bit,
  input wire logic pulse_launch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_launch_cause: assert property (pulse_launch |-> $past(send_pulse_set) && !$past(send_pulse_bit) && send_pulse_bit)
    else $error("launch without idle request");
  a_start_idle: assert property (send_pulse_set && !send_pulse_bit |=> pulse_launch)
    else $error("idle request not taken");
  a_busy_bound: assert property (pulse_launch |-> ##[1:256] !send_pulse_bit)
    else $error("capture overran window");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 5'h17 || reg_addr > 5'h1b) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_peak_resv: assert property (reg_rd && reg_addr == 5'h18 |=> reg_rdata[15:14] == 2'h0)
    else $error("peak reserved set");
  a_thr_resv: assert property (reg_rd && reg_addr == 5'h19 |=> reg_rdata[15:9] == 7'h00)
    else $error("threshold reserved set");
  a_var_resv: assert property (reg_rd && reg_addr == 5'h1a |=> reg_rdata[14:4] == 11'h000)
    else $error("variance reserved set");
  c_launch: cover property (pulse_launch);
  c_done: cover property ($fell(send_pulse_bit));
  c_data_rd: cover property (reg_rd && reg_addr == 5'h1b);
endmodule
bind cable_diag_result_regs cable_diag_result_regs_props #(.unit_log2(unit_log2)) props_inst (.mclk(mclk), .rstn(rstn),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .send_pulse_set(send_pulse_set),
  .send_pulse_bit(send_pulse_bit), .pulse_launch(pulse_launch));

// ---- dv/test_cable_diag_result_regs.sv ----
`timescale 1ns/1ps
module test_cable_diag_result_regs;
  logic mclk, rstn, reg_wr, reg_rd, send_pulse_set, negative_peak_mode, send_pulse_bit, pulse_launch, variance_sample_valid;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, got;
  logic [5:0] rx_threshold, sample;
  logic [31:0] variance_term;
  int err_total, compares, cycles, k, n;
  typedef struct {logic [15:0] win; logic neg; logic [5:0] thr; logic [15:0] peak, met;} row_s;
  row_s rows[4] = '{'{16'h000f, 1'b0, 6'h30, 16'h3a05, 16'h0105}, '{16'h060f, 1'b0, 6'h3a, 16'h3a09, 16'h0000},
    '{16'h000f, 1'b1, 6'h10, 16'h0507, 16'h0107}, '{16'h0808, 1'b1, 6'h20, 16'h2208, 16'h0000}};
  cable_diag_result_regs #(.unit_log2(4)) cable_diag_result_regs_inst (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .send_pulse_set(send_pulse_set),
    .negative_peak_mode(negative_peak_mode), .rx_threshold(rx_threshold), .send_pulse_bit(send_pulse_bit),
    .pulse_launch(pulse_launch), .sample(sample), .variance_sample_valid(variance_sample_valid),
    .variance_term(variance_term));
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end
  function automatic logic [5:0] wave(int t);
    if (t == 5 || t == 9) return 6'h3a;
    if (t == 7 || t == 12) return 6'h05;
    return 6'h20 + 6'(t % 3);
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
    compares++;
    if (exp !== seen) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(negedge mclk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 0;
  endtask
  task automatic rd(logic [4:0] a);
    @(negedge mclk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 0;
    @(negedge mclk);
    got = reg_rdata;
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, send_pulse_set, negative_peak_mode, variance_sample_valid} = '0;
    {reg_addr, reg_wdata, rx_threshold, sample, variance_term} = '0;
    repeat (20) @(posedge mclk);
    @(negedge mclk) rstn = 1;
    foreach (rows[i]) begin
      wr(5'h17, rows[i].win);
      negative_peak_mode = rows[i].neg;
      rx_threshold = rows[i].thr;
      @(negedge mclk) send_pulse_set = 1;
      @(negedge mclk) send_pulse_set = 0;
      chk("launch", 16'h0001, {15'h0000, pulse_launch});
      sample = wave(0);
      n = int'(send_pulse_bit === 1'b1);
      k = 1;
      do begin
        @(negedge mclk);
        if (send_pulse_bit === 1'b1) n++;
        sample = wave(k);
        k++;
      end while (send_pulse_bit === 1'b1 && k < 300);
      chk("busy", {8'h00, rows[i].win[7:0]} + 16'h0001, 16'(n));
      rd(5'h17);
      chk("window", rows[i].win, got);
      rd(5'h18);
      chk("peak", rows[i].peak, got);
      rd(5'h19);
      if (rows[i].met[8]) chk("thr", rows[i].met, got);
      else chk("met", 16'h0000, got & 16'h0100);
    end
    $display("Capture rows done");
    @(negedge mclk) rstn = 0;
    @(negedge mclk) rstn = 1;
    rd(5'h17);
    chk("win reset", 16'h00ff, got);
    rd(5'h1a);
    chk("var reset", 16'h0000, got);
    wr(5'h18, 16'hffff);
    rd(5'h18);
    chk("peak ro", 16'h0000, got);
    rd(5'h10);
    chk("unmapped", 16'h0000, got);
    $display("Reset test done");
    for (int s = 0; s < 4; s++) begin
      wr(5'h1a, 16'(s * 2 + 1));
      repeat (32 * (s + 1) - 10) @(negedge mclk);
      rd(5'h1a);
      chk("early", 16'h0000, got & 16'h8000);
      repeat (14) @(negedge mclk);
      rd(5'h1a);
      chk("ready", 16'h8000, got & 16'h8000);
      rd(5'h1b);
      rd(5'h1b);
    end
    rd(5'h1a);
    chk("cleared", 16'h0007, got);
    $display("Timer test done");
    wr(5'h1a, 16'h0001);
    variance_term = 32'h1234_0001;
    variance_sample_valid = 1;
    repeat (3) @(negedge mclk);
    variance_sample_valid = 0;
    repeat (40) @(negedge mclk);
    rd(5'h1a);
    chk("ready seen", 16'h8000, got & 16'h8000);
    wr(5'h1a, 16'h0009);
    repeat (40) @(negedge mclk);
    rd(5'h1b);
    chk("low", 16'h0003, got);
    rd(5'h1b);
    chk("high", 16'h369c, got);
    rd(5'h1a);
    chk("unfrozen", 16'h0001, got);
    $display("Freeze test done");
    complete_run();
  end
endmodule
